// ==== common/lla_pkg.sv ====
// shared constants and carriers for the link latency alignment block
package lla_pkg;
  localparam int NUM_LINKS = 2;
  localparam int LANES = 4;
  localparam int LANE_W = 32;
  localparam int DATA_W = LANES * LANE_W;
  localparam int FIFO_DEPTH = 8;
  localparam int REG_AW = 12;
  localparam int CNT_W = 8;
  // register map
  localparam logic [11:0] ADDR_LAT0 = 12'h0302;
  localparam logic [11:0] ADDR_LAT1 = 12'h0303;
  localparam logic [11:0] ADDR_OFS0 = 12'h0304;
  localparam logic [11:0] ADDR_OFS1 = 12'h0305;
  localparam logic [11:0] ADDR_DLY0 = 12'h0306;
  localparam logic [11:0] ADDR_DLY1 = 12'h0307;
  localparam logic [7:0] RESET_OFS = 8'h00;
  localparam logic [7:0] RESET_DLY = 8'h00;
  localparam logic [7:0] RESET_LAT = 8'h00;
  localparam logic [7:0] MAX_RELEASE_DELAY = 8'h0a;
  localparam logic [7:0] PROC_OCTETS = 8'h04;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] ZERO = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [REG_AW-1:0] addr;
    logic [7:0] wdata;
  } lla_reg_req_s;

  typedef struct packed {
    logic [7:0] k_frames;
    logic [7:0] octets_per_frame;
  } lla_cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RELEASE = 3'b100
  } lla_rel_e;
endpackage

// ==== src/lla_align.sv ====
// per-link local multiframe clock, latency measure and buffered release
//
// Contract
// - link alignment uncertainty within half converter clock
// - all lanes of link read together
// - per-link local multiframe clock, programmable offset
// - release delay accepts zero to ten cycles
// - frames per processing cycle equals four/F
// - offset in frames, delay in processing cycles
// - report latency from local edge to data
// - latency readback per link, consecutive addresses
// - readback wraps at multiframe; software unwraps
// - processing clock is byte rate over four
module lla_align
  import lla_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // sysref-aligned multiframe edge, one pulse per multiframe
  input wire logic sysref_mf_edge_in,
  input wire lla_pkg::lla_cfg_s cfg_in,
  // register port
  input wire lla_pkg::lla_reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_ack_out,
  // per-link lane data from deserialiser, all lanes of one link together
  input wire logic [lla_pkg::NUM_LINKS-1:0] lane_valid_in,
  input wire logic [lla_pkg::NUM_LINKS-1:0] ilas_done_in,
  input wire logic [lla_pkg::NUM_LINKS-1:0][lla_pkg::DATA_W-1:0] lane_data_in,
  output logic [lla_pkg::NUM_LINKS-1:0] lane_ready_out,
  // per-link output toward transport layer
  output logic [lla_pkg::NUM_LINKS-1:0] out_valid_out,
  output logic [lla_pkg::NUM_LINKS-1:0][lla_pkg::DATA_W-1:0] out_data_out,
  input wire logic [lla_pkg::NUM_LINKS-1:0] out_ready_in,
  output logic [lla_pkg::NUM_LINKS-1:0] local_mf_out
);
  import lla_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] offset;
    logic [CNT_W-1:0] delay;
    logic [CNT_W-1:0] latency;
    logic [CNT_W-1:0] frame_cnt;
    logic [CNT_W-1:0] lat_cnt;
    logic [CNT_W-1:0] rel_cnt;
    logic ilas_seen;
    logic measured;
    logic local_mf;
    lla_rel_e rel;
  } lla_link_s;

  typedef struct packed {
    lla_link_s [NUM_LINKS-1:0] lk;
    logic [7:0] rdata;
    logic ack;
    logic [NUM_LINKS-1:0] ovalid;
    logic [NUM_LINKS-1:0][DATA_W-1:0] odata;
  } lla_state_s;

  lla_state_s st;
  lla_state_s next_st;

  logic [NUM_LINKS-1:0] f_valid;
  logic [NUM_LINKS-1:0] f_ready;
  logic [NUM_LINKS-1:0][DATA_W-1:0] f_data;
  logic [CNT_W-1:0] frames_per_proc;
  logic [CNT_W-1:0] proc_per_mf;

  // ==========================================================
  // helpers
  function automatic logic [CNT_W-1:0] clamp_delay(input logic [CNT_W-1:0] v);
    clamp_delay = (v > MAX_RELEASE_DELAY) ? MAX_RELEASE_DELAY : v;
  endfunction

  function automatic logic hit(input logic [REG_AW-1:0] a, input logic [11:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // frame clocks per processing cycle, and cycles per multiframe
  always_comb
  begin
    frames_per_proc = (cfg_in.octets_per_frame == ZERO) ? ONE
      : PROC_OCTETS / cfg_in.octets_per_frame;
    proc_per_mf = cfg_in.k_frames / frames_per_proc;
    if (proc_per_mf == ZERO)
      proc_per_mf = ONE;
  end

  // ==========================================================
  // receive buffers, one per link so every lane leaves together
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINKS; gi++)
    begin : g_buf
      lla_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
      ) u_fifo (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .clk_en_in(clk_en_in),
        .in_valid_in(lane_valid_in[gi]),
        .in_ready_out(lane_ready_out[gi]),
        .in_data_in(lane_data_in[gi]),
        .out_valid_out(f_valid[gi]),
        .out_ready_in(f_ready[gi]),
        .out_data_out(f_data[gi])
      );
    end
  endgenerate

  // ==========================================================
  // next-state logic
  always_comb
  begin
    next_st = st;
    next_st.ack = 1'b0;
    f_ready = '0;
    for (int i = 0; i < NUM_LINKS; i++)
    begin
      // local multiframe clock: frame counter restarts on sysref edge,
      // local edge fires on the step that takes it past the offset (frames)
      next_st.lk[i].local_mf = 1'b0;
      if (sysref_mf_edge_in)
        next_st.lk[i].frame_cnt = frames_per_proc;
      else
        next_st.lk[i].frame_cnt = st.lk[i].frame_cnt + frames_per_proc;
      if (next_st.lk[i].frame_cnt >= cfg_in.k_frames && cfg_in.k_frames != ZERO)
        next_st.lk[i].frame_cnt = next_st.lk[i].frame_cnt - cfg_in.k_frames;
      // offset may fall between proc steps; fire on the step that crosses it
      if (st.lk[i].frame_cnt <= st.lk[i].offset
          && (next_st.lk[i].frame_cnt > st.lk[i].offset
              || next_st.lk[i].frame_cnt < st.lk[i].frame_cnt))
        next_st.lk[i].local_mf = 1'b1;
      // latency measure from local edge to first data after alignment
      if (st.lk[i].local_mf)
        next_st.lk[i].lat_cnt = '0;
      else if (st.lk[i].lat_cnt + ONE >= proc_per_mf)
        next_st.lk[i].lat_cnt = '0;
      else
        next_st.lk[i].lat_cnt = st.lk[i].lat_cnt + ONE;
      if (!ilas_done_in[i])
      begin
        next_st.lk[i].ilas_seen = 1'b1;
        next_st.lk[i].measured = 1'b0;
      end
      if (ilas_done_in[i] && st.lk[i].ilas_seen && !st.lk[i].measured && lane_valid_in[i])
      begin
        next_st.lk[i].latency = st.lk[i].local_mf ? ZERO : st.lk[i].lat_cnt;
        next_st.lk[i].measured = 1'b1;
      end
      // release machine: wait delay cycles after the first local edge, then stay in release
      next_st.ovalid[i] = st.ovalid[i] && !out_ready_in[i];
      unique case (st.lk[i].rel)
        ST_IDLE:
        begin
          if (st.lk[i].local_mf)
          begin
            next_st.lk[i].rel_cnt = st.lk[i].delay;
            next_st.lk[i].rel = (st.lk[i].delay == ZERO) ? ST_RELEASE : ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          next_st.lk[i].rel_cnt = st.lk[i].rel_cnt - ONE;
          if (st.lk[i].rel_cnt == ONE)
            next_st.lk[i].rel = ST_RELEASE;
        end
        ST_RELEASE:
        begin
          // all lanes of the link leave in one word
          if (f_valid[i] && (!st.ovalid[i] || out_ready_in[i]))
          begin
            f_ready[i] = 1'b1;
            next_st.ovalid[i] = 1'b1;
            next_st.odata[i] = f_data[i];
          end
        end
        default:
          next_st.lk[i].rel = ST_IDLE;
      endcase
    end
    // register port, byte-wide
    if (reg_req_in.wr)
    begin
      next_st.ack = 1'b1;
      if (hit(reg_req_in.addr, ADDR_OFS0))
        next_st.lk[0].offset = reg_req_in.wdata;
      if (hit(reg_req_in.addr, ADDR_OFS1))
        next_st.lk[1].offset = reg_req_in.wdata;
      if (hit(reg_req_in.addr, ADDR_DLY0))
        next_st.lk[0].delay = clamp_delay(reg_req_in.wdata);
      if (hit(reg_req_in.addr, ADDR_DLY1))
        next_st.lk[1].delay = clamp_delay(reg_req_in.wdata);
    end
    else if (reg_req_in.rd)
    begin
      next_st.ack = 1'b1;
      unique case (1'b1)
        hit(reg_req_in.addr, ADDR_LAT0): next_st.rdata = st.lk[0].latency;
        hit(reg_req_in.addr, ADDR_LAT1): next_st.rdata = st.lk[1].latency;
        hit(reg_req_in.addr, ADDR_OFS0): next_st.rdata = st.lk[0].offset;
        hit(reg_req_in.addr, ADDR_OFS1): next_st.rdata = st.lk[1].offset;
        hit(reg_req_in.addr, ADDR_DLY0): next_st.rdata = st.lk[0].delay;
        hit(reg_req_in.addr, ADDR_DLY1): next_st.rdata = st.lk[1].delay;
        default: next_st.rdata = READ_ZERO;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      st <= '0;
      for (int i = 0; i < NUM_LINKS; i++)
      begin
        st.lk[i].offset <= RESET_OFS;
        st.lk[i].delay <= RESET_DLY;
        st.lk[i].latency <= RESET_LAT;
        st.lk[i].rel <= ST_IDLE;
      end
    end
    else if (clk_en_in)
      st <= next_st;
  end

  // ==========================================================
  // outputs, all from state flops
  always_comb
  begin
    reg_rdata_out = st.rdata;
    reg_ack_out = st.ack;
    out_valid_out = st.ovalid;
    out_data_out = st.odata;
    for (int i = 0; i < NUM_LINKS; i++)
      local_mf_out[i] = st.lk[i].local_mf;
  end
endmodule // lla_align

// ==== src/lla_fifo.sv ====
// parameterised flop fifo with valid/ready on both sides
module lla_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } lla_fifo_s;

  lla_fifo_s st;
  lla_fifo_s next_st;
  logic push;
  logic pop;

  // ==========================================================
  // control
  always_comb
  begin
    next_st = st;
    push = in_valid_in && (st.cnt != (PW+1)'(DEPTH));
    pop = out_ready_in && (st.cnt != '0);
    if (push)
    begin
      next_st.mem[st.wp] = in_data_in;
      next_st.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : st.wp + PW'(1);
    end
    if (pop)
      next_st.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : st.rp + PW'(1);
    next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      st <= '0;
    else if (clk_en_in)
      st <= next_st;
  end

  // ready and valid straight from state flops
  assign in_ready_out = (st.cnt != (PW+1)'(DEPTH));
  assign out_valid_out = (st.cnt != '0);
  assign out_data_out = st.mem[st.rp];
endmodule // lla_fifo

// ==== verif/lla_align_asserts.sv ====
// port checker for the link latency alignment block
module lla_align_chk
  import lla_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // register port
  input wire lla_pkg::lla_reg_req_s reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_ack_out,
  // output side
  input wire logic [lla_pkg::NUM_LINKS-1:0] out_valid_out,
  input wire logic [lla_pkg::NUM_LINKS-1:0][lla_pkg::DATA_W-1:0] out_data_out,
  input wire logic [lla_pkg::NUM_LINKS-1:0] out_ready_in,
  input wire logic [lla_pkg::NUM_LINKS-1:0] local_mf_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // properties
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic mf_seen;
  always_ff @(posedge mclk_in)
    if (!reset_n_in)
      mf_seen <= 1'b0;
    else if (local_mf_out[0])
      mf_seen <= 1'b1;
  sequence req_s;
    (reg_req_in.wr || reg_req_in.rd) && clk_en_in;
  endsequence
  sequence rd_s;
    reg_req_in.rd && !reg_req_in.wr && clk_en_in;
  endsequence
  ack_follows_req_a: assert property (req_s |=> reg_ack_out)
    else $error("ack missing after request");
  ack_has_cause_a: assert property (reg_ack_out |-> $past(reg_req_in.wr || reg_req_in.rd))
    else $error("ack without request");
  rdata_holds_a: assert property (!(reg_req_in.rd && clk_en_in) |=> $stable(reg_rdata_out))
    else $error("read data moved without read");
  unmapped_reads_zero_a: assert property ((rd_s ##0 (reg_req_in.addr < ADDR_LAT0
    || reg_req_in.addr > ADDR_DLY1)) |=> reg_rdata_out == READ_ZERO)
    else $error("unmapped read not zero");
  delay_clamped_a: assert property ((rd_s ##0 (reg_req_in.addr == ADDR_DLY0
    || reg_req_in.addr == ADDR_DLY1)) |=> reg_rdata_out <= MAX_RELEASE_DELAY)
    else $error("release delay above ten");
  edge_pulse_a: assert property (local_mf_out != 2'b00 |=> (local_mf_out & $past(local_mf_out)) == 2'b00)
    else $error("local edge longer than one cycle");
  out_held_a: assert property (out_valid_out[0] && !out_ready_in[0] |=> out_valid_out[0]
    && $stable(out_data_out[0]))
    else $error("output dropped while stalled");
  release_after_edge_a: assert property (out_valid_out[0] |-> mf_seen)
    else $error("data released before local edge");
endmodule // lla_align_chk

bind lla_align lla_align_chk u_chk (.mclk_in, .reset_n_in, .clk_en_in, .reg_req_in,
  .reg_rdata_out, .reg_ack_out, .out_valid_out, .out_data_out, .out_ready_in, .local_mf_out);

// ==== verif/lla_link_tx.sv ====
// transmitter model feeding the lanes of one link
module lla_link_tx
  import lla_pkg::*;
#(
  parameter int NWORDS = 20
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // link side
  input wire logic go_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic ilas_done_out,
  output logic [lla_pkg::DATA_W-1:0] data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int n;
  int t;
  int nx;
  logic send;
  initial {valid_out, ilas_done_out, data_out} = '0;
  always @(posedge mclk_in)
  begin
    nx = n + int'(valid_out && ready_in);
    // every third cycle idle, keeps arrival spread small
    send = go_in && t % 3 != 2 && nx < NWORDS;
    t <= t + 1;
    n <= nx;
    if (!valid_out || ready_in)
    begin
      valid_out <= send;
      ilas_done_out <= nx >= 4;
      // idle line shows the inverse; a second idle cycle in a row shows the stale word again
      data_out <= send ? DATA_W'(nx) : ~data_out;
    end
    if (!reset_n_in)
    begin
      n <= 0;
      t <= 0;
      valid_out <= 1'b0;
    end
  end
endmodule // lla_link_tx

// ==== verif/testbench.sv ====
// self-checking bench for the link latency alignment block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import lla_pkg::*;
  typedef struct packed {logic [11:0] addr; logic [7:0] wdata; logic [7:0] exp;} lla_row_s;
  localparam lla_row_s ROWS [7] = '{'{ADDR_OFS0, 8'h00, 8'h00}, '{ADDR_OFS1, 8'h06, 8'h06},
    '{ADDR_DLY0, 8'h0a, 8'h0a}, '{ADDR_DLY1, 8'h0b, 8'h0a}, '{ADDR_DLY1, 8'h00, 8'h00},
    '{ADDR_LAT0, 8'h55, 8'h00}, '{12'h0308, 8'h33, 8'h00}};
  logic mclk_in, reset_n_in, clk_en_in, sysref, go, ack;
  lla_cfg_s cfg = '{8'h10, 8'h02};
  lla_reg_req_s req;
  logic [7:0] rdata, q, mn, mx, ofs, dly;
  logic [7:0] lat [2];
  logic [1:0] lvalid, ilas, lready, ovalid, oready, mf;
  logic [1:0][DATA_W-1:0] ldata, odata;
  int failures, checks_done, n, per;
  int k [2];
  lla_align u_dut (.mclk_in, .reset_n_in, .clk_en_in, .sysref_mf_edge_in(sysref), .cfg_in(cfg),
    .reg_req_in(req), .reg_rdata_out(rdata), .reg_ack_out(ack), .lane_valid_in(lvalid),
    .ilas_done_in(ilas), .lane_data_in(ldata), .lane_ready_out(lready), .out_valid_out(ovalid),
    .out_data_out(odata), .out_ready_in(oready), .local_mf_out(mf));
  lla_link_tx u_tx0 (.mclk_in, .reset_n_in, .go_in(go), .ready_in(lready[0]),
    .valid_out(lvalid[0]), .ilas_done_out(ilas[0]), .data_out(ldata[0]));
  lla_link_tx u_tx1 (.mclk_in, .reset_n_in, .go_in(go), .ready_in(lready[1]),
    .valid_out(lvalid[1]), .ilas_done_out(ilas[1]), .data_out(ldata[1]));
  // ==========
  // tasks
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic reg_op(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [7:0] r);
    @(negedge mclk_in);
    req = '{w, !w, a, d};
    @(negedge mclk_in);
    req = '0;
    check(ack, 1'b1);
    r = rdata;
  endtask
  task automatic wait_mf(input int l, output int c);
    c = 0;
    do
    begin
      @(negedge mclk_in);
      c++;
    end
    while (mf[l] !== 1'b1 && c < 64);
    if (mf[l] !== 1'b1)
    begin
      failures++;
      test_done();
    end
  endtask
  // ==========
  // sequence
  initial
  begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  initial
  begin
    req = '0;
    clk_en_in = 1'b1;
    sysref = 1'b0;
    go = 1'b0;
    oready = 2'b11;
    reset_n_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    reset_n_in = 1'b1;
    sysref = 1'b1;
    @(negedge mclk_in);
    sysref = 1'b0;
    for (int a = 0; a < 6; a++)
    begin
      reg_op(1'b0, ADDR_LAT0 + 12'(a), 8'h00, q);
      check(q, 8'h00);
    end
    foreach (ROWS[i])
    begin
      reg_op(1'b1, ROWS[i].addr, ROWS[i].wdata, q);
      reg_op(1'b0, ROWS[i].addr, 8'h00, q);
      check(q, ROWS[i].exp);
    end
    per = cfg.k_frames * cfg.octets_per_frame / 4;
    wait_mf(0, n);
    wait_mf(0, n);
    check(n, per);
    wait_mf(0, n);
    wait_mf(1, n);
    check(n, 6 * cfg.octets_per_frame / 4);
    reg_op(1'b1, ADDR_OFS1, 8'h00, q);
    // fill until refused, far side keeps stalling
    oready = 2'b00;
    go = 1'b1;
    for (n = 0; n < 200 && lready !== 2'b00; n++)
      @(negedge mclk_in);
    check(lready, 2'b00);
    oready = 2'b11;
    k = '{0, 0};
    for (n = 0; n < 400 && (k[0] < 20 || k[1] < 20); n++)
    begin
      for (int l = 0; l < 2; l++)
        if (ovalid[l] === 1'b1)
        begin
          check(odata[l], 128'(k[l]));
          k[l]++;
        end
      @(negedge mclk_in);
    end
    check(k[0] + k[1], 40);
    check({ovalid, lready}, 4'b0011);
    reg_op(1'b0, ADDR_LAT0, 8'h00, lat[0]);
    reg_op(1'b0, ADDR_LAT1, 8'h00, lat[1]);
    check(lat[0] < per && lat[1] < per, 1'b1);
    mn = (lat[0] < lat[1]) ? lat[0] : lat[1];
    mx = (lat[0] < lat[1]) ? lat[1] : lat[0];
    dly = mx + 8'h01 - (mn - 8'h01);
    ofs = 8'(((mn + per - 1) * 4 / cfg.octets_per_frame) % cfg.k_frames);
    for (int l = 0; l < 2; l++)
    begin
      reg_op(1'b1, ADDR_OFS0 + 12'(l), ofs, q);
      reg_op(1'b1, ADDR_DLY0 + 12'(l), dly, q);
      reg_op(1'b0, ADDR_OFS0 + 12'(l), 8'h00, q);
      check(q, ofs);
      reg_op(1'b0, ADDR_DLY0 + 12'(l), 8'h00, q);
      check(q, dly);
    end
    // mid-run reset: settings and buffers must return to idle
    go = 1'b0;
    reset_n_in = 1'b0;
    @(negedge mclk_in);
    reset_n_in = 1'b1;
    check({ovalid, lready, mf}, 6'b001100);
    reg_op(1'b0, ADDR_DLY0, 8'h00, q);
    check(q, RESET_DLY);
    reg_op(1'b0, ADDR_OFS1, 8'h00, q);
    check(q, RESET_OFS);
    test_done();
  end
endmodule // testbench
